// File: hw/monitor_config_regs.sv
// Design decision made here: register access over Wishbone.
`timescale 1ns/10ps
module monitor_config_regs #(
	parameter longint       TICK_CYCLES = monitor_cfg_pkg::TICK_CYCLES_DEF,
	parameter logic [7:0]   PART_ID     = monitor_cfg_pkg::ID_PART_DEFAULT,
	parameter logic [7:0]   SILICON_REV = monitor_cfg_pkg::ID_REV_DEFAULT,
	parameter logic [7:0]   DEVICE_REV  = monitor_cfg_pkg::ID_DEVREV_DEFAULT,
	parameter logic [63:0]  DIE_BYTES   = 64'h0123456789ABCDEF
) (
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [13:0]                   wb_adr_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic [31:0]                   wb_dat_i,
	output logic [31:0]                        wb_dat_o,
	output logic                               wb_ack_o,
	input  wire logic                          frame_valid_i,
	input  wire logic                          wake_to_active_i,
	input  wire logic                          go_sleep_i,
	input  wire logic                          fault_detected_i,
	input  wire logic                          link_fault_state_i,
	input  wire logic                          alarm_tone_req_i,
	input  wire logic                          sleep_pulse_req_i,
	input  wire logic [15:0]                   balance_req_i,
	input  wire logic                          link_flag_clear_i,
	output monitor_cfg_pkg::config_t           config_o,
	output monitor_cfg_pkg::port_enable_t      port_enable_o,
	output monitor_cfg_pkg::power_t            power_state_o,
	output logic                               link_timeout_flag_o,
	output logic                               link_fault_o,
	output logic                               fault_pin_o,
	output logic                               alarm_tone_o,
	output logic                               sleep_pulse_o,
	output logic [15:0]                        balance_o,
	output logic [4:0]                         cells_active_o,
	output logic [6:0]                         thermal_warning_c_o,
	output logic [15:0]                        holdoff_bits_o,
	output logic [13:0]                        chain_delay_cycles_o
);
	logic [7:0] dev_cfg_q, cell_cnt_q, bb_hi_q, bb_lo_q, pwr_cfg_q;
	logic [7:0] to_cfg_q, holdoff_q, delay_q, pin_loc_q;
	logic       link_flag_q, ack_q;
	logic [31:0] rdata_q;
	logic [31:0] tick_q;
	logic        tick;
	logic [16:0] short_cnt_q, long_cnt_q, sleep_cnt_q;
	logic        short_hit, long_hit, sleep_hit;
	monitor_cfg_pkg::power_t pwr_q;
	logic [11:0] idx;
	logic        wr;
	logic [7:0]  rd_byte;
	logic [63:0] die_bytes;
	logic [11:0] die_off;

	// only the low byte lane carries register data
	assign idx = wb_adr_i[13:2];
	assign wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && ack_q;
	assign die_bytes = DIE_BYTES;
	assign die_off   = idx - monitor_cfg_pkg::IDX_FACTORY_DIE_FIRST;

	function automatic logic [16:0] link_limit(input logic [2:0] c);
		unique case (c)
			3'h1:    link_limit = 17'(monitor_cfg_pkg::LINK_TO_100MS);
			3'h2:    link_limit = 17'(monitor_cfg_pkg::LINK_TO_2S);
			3'h3:    link_limit = 17'(monitor_cfg_pkg::LINK_TO_10S);
			3'h4:    link_limit = 17'(monitor_cfg_pkg::LINK_TO_1MIN);
			3'h5:    link_limit = 17'(monitor_cfg_pkg::LINK_TO_10MIN);
			3'h6:    link_limit = 17'(monitor_cfg_pkg::LINK_TO_30MIN);
			3'h7:    link_limit = 17'(monitor_cfg_pkg::LINK_TO_1HR);
			default: link_limit = 17'h00000;
		endcase
	endfunction : link_limit

	function automatic logic [16:0] sleep_limit(input logic [2:0] c);
		unique case (c)
			3'h1:    sleep_limit = 17'(monitor_cfg_pkg::SLEEP_TO_5S);
			3'h2:    sleep_limit = 17'(monitor_cfg_pkg::LINK_TO_10S);
			3'h3:    sleep_limit = 17'(monitor_cfg_pkg::LINK_TO_1MIN);
			3'h4:    sleep_limit = 17'(monitor_cfg_pkg::LINK_TO_10MIN);
			3'h5:    sleep_limit = 17'(monitor_cfg_pkg::LINK_TO_30MIN);
			3'h6:    sleep_limit = 17'(monitor_cfg_pkg::LINK_TO_1HR);
			3'h7:    sleep_limit = 17'(monitor_cfg_pkg::SLEEP_TO_2HR);
			default: sleep_limit = 17'h00000;
		endcase
	endfunction : sleep_limit

	// a write lands on the edge where the master sees ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dev_cfg_q  <= monitor_cfg_pkg::RST_DEVICE_CONFIG;
			cell_cnt_q <= monitor_cfg_pkg::RST_SERIES_CELL_COUNT;
			bb_hi_q    <= monitor_cfg_pkg::RST_BUSBAR_CHANNELS;
			bb_lo_q    <= monitor_cfg_pkg::RST_BUSBAR_CHANNELS;
			pwr_cfg_q  <= monitor_cfg_pkg::RST_POWER_TRANSITION;
			to_cfg_q   <= monitor_cfg_pkg::RST_LINK_TIMEOUT_CONFIG;
			holdoff_q  <= monitor_cfg_pkg::RST_RESPONSE_HOLDOFF;
			delay_q    <= monitor_cfg_pkg::RST_CHAIN_RESPONSE_DELAY;
			pin_loc_q  <= monitor_cfg_pkg::RST_BUSBAR_PIN_LOCATION;
		end else if (wr) begin
			unique case (idx)
				monitor_cfg_pkg::IDX_DEVICE_CONFIG:
					dev_cfg_q <= wb_dat_i[7:0];
				monitor_cfg_pkg::IDX_SERIES_CELL_COUNT:
					cell_cnt_q <= wb_dat_i[7:0];
				monitor_cfg_pkg::IDX_BUSBAR_CHANNELS_HIGH:
					bb_hi_q <= wb_dat_i[7:0];
				monitor_cfg_pkg::IDX_BUSBAR_CHANNELS_LOW:
					bb_lo_q <= wb_dat_i[7:0];
				monitor_cfg_pkg::IDX_POWER_TRANSITION:
					pwr_cfg_q <= wb_dat_i[7:0];
				monitor_cfg_pkg::IDX_LINK_TIMEOUT_CONFIG:
					to_cfg_q <= wb_dat_i[7:0];
				monitor_cfg_pkg::IDX_RESPONSE_HOLDOFF:
					holdoff_q <= wb_dat_i[7:0];
				monitor_cfg_pkg::IDX_CHAIN_RESPONSE_DELAY:
					delay_q <= wb_dat_i[7:0];
				monitor_cfg_pkg::IDX_BUSBAR_PIN_LOCATION:
					pin_loc_q <= wb_dat_i[7:0];
				default: ; // identity bytes ignore writes
			endcase
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		if (idx >= monitor_cfg_pkg::IDX_FACTORY_DIE_FIRST &&
		    idx <= monitor_cfg_pkg::IDX_FACTORY_DIE_LAST) begin
			rd_byte = die_bytes[{die_off[2:0], 3'b000} +: 8];
		end else begin
			unique case (idx)
				monitor_cfg_pkg::IDX_DEVICE_CONFIG:        rd_byte = dev_cfg_q;
				monitor_cfg_pkg::IDX_SERIES_CELL_COUNT:    rd_byte = cell_cnt_q;
				monitor_cfg_pkg::IDX_BUSBAR_CHANNELS_HIGH: rd_byte = bb_hi_q;
				monitor_cfg_pkg::IDX_BUSBAR_CHANNELS_LOW:  rd_byte = bb_lo_q;
				monitor_cfg_pkg::IDX_POWER_TRANSITION:     rd_byte = pwr_cfg_q;
				monitor_cfg_pkg::IDX_LINK_TIMEOUT_CONFIG:  rd_byte = to_cfg_q;
				monitor_cfg_pkg::IDX_RESPONSE_HOLDOFF:     rd_byte = holdoff_q;
				monitor_cfg_pkg::IDX_CHAIN_RESPONSE_DELAY: rd_byte = delay_q;
				monitor_cfg_pkg::IDX_BUSBAR_PIN_LOCATION:  rd_byte = pin_loc_q;
				monitor_cfg_pkg::IDX_PART_IDENTITY:        rd_byte = PART_ID;
				monitor_cfg_pkg::IDX_SILICON_REVISION:     rd_byte = SILICON_REV;
				monitor_cfg_pkg::IDX_DEVICE_REVISION_CODE: rd_byte = DEVICE_REV;
				monitor_cfg_pkg::IDX_RUN_STATUS:
					rd_byte = {5'h00, link_flag_q, pwr_q};
				default: rd_byte = 8'h00;
			endcase
		end
	end

	// unmapped reads answer zero rather than err
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_q <= 1'b0;
		else
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			rdata_q <= 32'h00000000;
		else
			rdata_q <= {24'h000000, rd_byte};
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

	// common 100 ms time base
	always_ff @(posedge clk_i) begin
		if (rst_i || tick)
			tick_q <= 32'h00000000;
		else
			tick_q <= tick_q + 32'h00000001;
	end
	assign tick = (tick_q == 32'(TICK_CYCLES - 1));

	assign short_hit = (to_cfg_q[6:4] != 3'h0) &&
		(short_cnt_q == link_limit(to_cfg_q[6:4]));
	assign long_hit = (to_cfg_q[2:0] != 3'h0) &&
		(long_cnt_q == link_limit(to_cfg_q[2:0]));
	assign sleep_hit = (pwr_cfg_q[2:0] != 3'h0) &&
		(sleep_cnt_q == sleep_limit(pwr_cfg_q[2:0]));

	// link counters hold after expiry until a frame restarts them; the sleep counter clears outside sleep
	always_ff @(posedge clk_i) begin
		if (rst_i || frame_valid_i || to_cfg_q[6:4] == 3'h0)
			short_cnt_q <= 17'h00000;
		else if (tick && !short_hit && pwr_q == monitor_cfg_pkg::PWR_ACTIVE)
			short_cnt_q <= short_cnt_q + 17'h00001;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || frame_valid_i || to_cfg_q[2:0] == 3'h0)
			long_cnt_q <= 17'h00000;
		else if (tick && !long_hit && pwr_q == monitor_cfg_pkg::PWR_ACTIVE)
			long_cnt_q <= long_cnt_q + 17'h00001;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || pwr_q != monitor_cfg_pkg::PWR_SLEEP)
			sleep_cnt_q <= 17'h00000;
		else if (tick && !sleep_hit)
			sleep_cnt_q <= sleep_cnt_q + 17'h00001;
	end

	// set wins over clear
	always_ff @(posedge clk_i) begin
		if (rst_i)
			link_flag_q <= 1'b0;
		else if ((short_hit && short_cnt_q != 17'h00000 && tick) ||
		         (long_hit && tick && !to_cfg_q[3]))
			link_flag_q <= 1'b1;
		else if (link_flag_clear_i)
			link_flag_q <= 1'b0;
	end

	// shutdown is terminal until reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwr_q <= monitor_cfg_pkg::PWR_ACTIVE;
		end else begin
			unique case (pwr_q)
				monitor_cfg_pkg::PWR_ACTIVE: begin
					if (long_hit && tick && to_cfg_q[3])
						pwr_q <= monitor_cfg_pkg::PWR_SHUTDOWN;
					else if ((long_hit && tick) || go_sleep_i)
						pwr_q <= monitor_cfg_pkg::PWR_SLEEP;
				end
				monitor_cfg_pkg::PWR_SLEEP: begin
					if (sleep_hit && tick)
						pwr_q <= monitor_cfg_pkg::PWR_SHUTDOWN;
					else if (wake_to_active_i)
						pwr_q <= monitor_cfg_pkg::PWR_ACTIVE;
				end
				monitor_cfg_pkg::PWR_SHUTDOWN: ;
				default: pwr_q <= monitor_cfg_pkg::PWR_ACTIVE;
			endcase
		end
	end

	// balancing gate: no two adjacent switches when blocked
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_bal
			if (g == 0) begin : g_first
				assign balance_o[g] = balance_req_i[g];
			end else begin : g_rest
				assign balance_o[g] = balance_req_i[g] &&
					!(dev_cfg_q[monitor_cfg_pkg::DC_BLOCK_ADJ] &&
					  balance_o[g-1]);
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i)
			fault_pin_o <= 1'b1;
		else
			fault_pin_o <= !(dev_cfg_q[monitor_cfg_pkg::DC_FAULT_PIN] &&
				fault_detected_i);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			alarm_tone_o <= 1'b0;
		else
			alarm_tone_o <= alarm_tone_req_i &&
				pwr_q == monitor_cfg_pkg::PWR_SLEEP &&
				dev_cfg_q[monitor_cfg_pkg::DC_ALARM_TONE];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			sleep_pulse_o <= 1'b0;
		else
			sleep_pulse_o <= sleep_pulse_req_i &&
				pwr_q == monitor_cfg_pkg::PWR_SLEEP &&
				dev_cfg_q[monitor_cfg_pkg::DC_SLEEP_PULSE];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			link_fault_o <= 1'b0;
		else
			link_fault_o <= link_fault_state_i &&
				pwr_q == monitor_cfg_pkg::PWR_ACTIVE &&
				dev_cfg_q[monitor_cfg_pkg::DC_LINK_FAULT];
	end

	assign config_o.block_adjacent_balancing =
		dev_cfg_q[monitor_cfg_pkg::DC_BLOCK_ADJ];
	assign config_o.multidrop = dev_cfg_q[monitor_cfg_pkg::DC_MULTIDROP];
	assign config_o.link_fault_detect_enable =
		dev_cfg_q[monitor_cfg_pkg::DC_LINK_FAULT];
	assign config_o.two_stop_bits =
		dev_cfg_q[monitor_cfg_pkg::DC_TWO_STOP];
	assign config_o.fault_pin_enable = dev_cfg_q[monitor_cfg_pkg::DC_FAULT_PIN];
	assign config_o.sleep_alarm_tone_enable =
		dev_cfg_q[monitor_cfg_pkg::DC_ALARM_TONE];
	assign config_o.sleep_pulse_enable =
		dev_cfg_q[monitor_cfg_pkg::DC_SLEEP_PULSE];
	assign config_o.cell_count_code = cell_cnt_q[3:0];
	assign config_o.busbar_cells = {bb_hi_q, bb_lo_q};
	assign config_o.thermal_warning_level = pwr_cfg_q[4:3];
	assign config_o.busbar_pin_position = pin_loc_q[4:0];
	assign config_o.holdoff_bit_count = holdoff_q;
	assign config_o.chain_delay_steps = delay_q[5:0];

	// multidrop: chain ports off
	assign port_enable_o = dev_cfg_q[monitor_cfg_pkg::DC_MULTIDROP] ?
		4'h0 : 4'hF;
	assign power_state_o = pwr_q;
	assign link_timeout_flag_o = link_flag_q;
	assign cells_active_o = 5'(cell_cnt_q[3:0]) + 5'h06;
	assign thermal_warning_c_o = 7'h55 + 7'(pwr_cfg_q[4:3]) * 7'h0A;
	assign holdoff_bits_o = {8'h00, holdoff_q};
	assign chain_delay_cycles_o = 14'(delay_q[5:0]) *
		14'(monitor_cfg_pkg::STEP_CYCLES);

endmodule : monitor_config_regs

// File: inc/monitor_cfg_pkg.sv
package monitor_cfg_pkg;

	// register indices (byte address = index * 4)
	localparam logic [11:0] IDX_DEVICE_CONFIG          = 12'h002;
	localparam logic [11:0] IDX_SERIES_CELL_COUNT      = 12'h003;
	localparam logic [11:0] IDX_BUSBAR_CHANNELS_HIGH   = 12'h005;
	localparam logic [11:0] IDX_BUSBAR_CHANNELS_LOW    = 12'h006;
	localparam logic [11:0] IDX_POWER_TRANSITION       = 12'h018;
	localparam logic [11:0] IDX_LINK_TIMEOUT_CONFIG    = 12'h019;
	localparam logic [11:0] IDX_RESPONSE_HOLDOFF       = 12'h01A;
	localparam logic [11:0] IDX_CHAIN_RESPONSE_DELAY   = 12'h029;
	localparam logic [11:0] IDX_BUSBAR_PIN_LOCATION    = 12'h02A;
	localparam logic [11:0] IDX_PART_IDENTITY          = 12'h500;
	localparam logic [11:0] IDX_SILICON_REVISION       = 12'h501;
	localparam logic [11:0] IDX_FACTORY_DIE_FIRST      = 12'h502;
	localparam logic [11:0] IDX_FACTORY_DIE_LAST       = 12'h509;
	localparam logic [11:0] IDX_DEVICE_REVISION_CODE   = 12'hE00;
	localparam logic [11:0] IDX_RUN_STATUS             = 12'hF00;

	localparam logic [7:0] RST_DEVICE_CONFIG        = 8'h54;
	localparam logic [7:0] RST_SERIES_CELL_COUNT    = 8'h00;
	localparam logic [7:0] RST_BUSBAR_CHANNELS      = 8'h00;
	localparam logic [7:0] RST_POWER_TRANSITION     = 8'h18;
	localparam logic [7:0] RST_LINK_TIMEOUT_CONFIG  = 8'h00;
	localparam logic [7:0] RST_RESPONSE_HOLDOFF     = 8'h00;
	localparam logic [7:0] RST_CHAIN_RESPONSE_DELAY = 8'h00;
	localparam logic [7:0] RST_BUSBAR_PIN_LOCATION  = 8'h00;

	// device_config bits
	localparam int DC_BLOCK_ADJ   = 6;
	localparam int DC_MULTIDROP   = 5;
	localparam int DC_LINK_FAULT  = 4;
	localparam int DC_TWO_STOP    = 3;
	localparam int DC_FAULT_PIN   = 2;
	localparam int DC_ALARM_TONE  = 1;
	localparam int DC_SLEEP_PULSE = 0;
	// field positions
	localparam int CELL_COUNT_LSB = 0;
	localparam int THERM_LSB      = 3;
	localparam int SLEEP_TO_LSB   = 0;
	localparam int SHORT_TO_LSB   = 4;
	localparam int LONG_ACT_BIT   = 3;
	localparam int LONG_TO_LSB    = 0;
	localparam int DELAY_LSB      = 0;
	localparam int PIN_POS_LSB    = 0;

	// timing
	localparam longint CLK_HZ          = 200_000_000;
	localparam longint STEP_PS         = 250_000;
	localparam longint CLK_PS          = 5_000;
	localparam int     STEP_CYCLES     = int'(STEP_PS / CLK_PS);
	localparam longint TICK_MS         = 100;
	localparam longint TICK_CYCLES_DEF = CLK_HZ * TICK_MS / 1000;
	// durations in 100 ms ticks
	localparam int LINK_TO_100MS  = 1;
	localparam int LINK_TO_2S     = 20;
	localparam int LINK_TO_10S    = 100;
	localparam int LINK_TO_1MIN   = 600;
	localparam int LINK_TO_10MIN  = 6000;
	localparam int LINK_TO_30MIN  = 18000;
	localparam int LINK_TO_1HR    = 36000;
	localparam int SLEEP_TO_5S    = 50;
	localparam int SLEEP_TO_2HR   = 72000;

	// arbitrary identity values
	localparam logic [7:0] ID_PART_DEFAULT  = 8'h5A;
	localparam logic [7:0] ID_REV_DEFAULT   = 8'hA5;
	localparam logic [7:0] ID_DEVREV_DEFAULT = 8'h3C;

	typedef struct packed {
		logic       block_adjacent_balancing;
		logic       multidrop;
		logic       link_fault_detect_enable;
		logic       two_stop_bits;
		logic       fault_pin_enable;
		logic       sleep_alarm_tone_enable;
		logic       sleep_pulse_enable;
		logic [3:0] cell_count_code;
		logic [15:0] busbar_cells;
		logic [1:0] thermal_warning_level;
		logic [4:0] busbar_pin_position;
		logic [7:0] holdoff_bit_count;
		logic [5:0] chain_delay_steps;
	} config_t;

	typedef struct packed {
		logic lower_chain_port_tx;
		logic lower_chain_port_rx;
		logic upper_chain_port_tx;
		logic upper_chain_port_rx;
	} port_enable_t;

	typedef enum logic [1:0] {
		PWR_ACTIVE   = 2'b00,
		PWR_SLEEP    = 2'b01,
		PWR_SHUTDOWN = 2'b10
	} power_t;

endpackage : monitor_cfg_pkg

// File: tb/link_host_model.sv
`timescale 1ns/10ps
module link_host_model (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic en_i,
	input  wire logic slow_i,
	input  wire logic two_stop_i,
	output logic      frame_valid_o
);
	logic [7:0] cnt_q;
	logic [7:0] gap;
	// one frame every bits-per-frame times bit period plus one cycle; slow host uses a six times longer bit period
	assign gap = (two_stop_i ? 8'h0B : 8'h0A) * (slow_i ? 8'h0C : 8'h02);
	always_ff @(posedge clk_i) begin
		if (rst_i || !en_i) begin
			cnt_q <= 8'h00;
			frame_valid_o <= 1'b0;
		end else begin
			frame_valid_o <= (cnt_q == gap);
			cnt_q <= (cnt_q == gap) ? 8'h00 : cnt_q + 8'h01;
		end
	end
endmodule : link_host_model

// File: tb/monitor_config_regs_assertions.sv
`timescale 1ns/10ps
module monitor_config_regs_checker (
	input wire logic                          clk_i,
	input wire logic                          rst_i,
	input wire logic                          wb_cyc_i,
	input wire logic                          wb_stb_i,
	input wire logic                          wb_ack_o,
	input wire logic                          fault_detected_i,
	input wire monitor_cfg_pkg::config_t      config_o,
	input wire monitor_cfg_pkg::port_enable_t port_enable_o,
	input wire monitor_cfg_pkg::power_t       power_state_o,
	input wire logic                          link_timeout_flag_o,
	input wire logic                          link_fault_o,
	input wire logic                          fault_pin_o,
	input wire logic                          alarm_tone_o,
	input wire logic                          sleep_pulse_o,
	input wire logic [15:0]                   balance_o,
	input wire logic [4:0]                    cells_active_o,
	input wire logic [6:0]                    thermal_warning_c_o,
	input wire logic [15:0]                   holdoff_bits_o,
	input wire logic [13:0]                   chain_delay_cycles_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_latency_a: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	cell_map_a: assert property (
		cells_active_o == 5'(config_o.cell_count_code) + 5'h06)
		else $error("cell count decode wrong");
	therm_map_a: assert property (thermal_warning_c_o ==
		7'h55 + 7'(config_o.thermal_warning_level) * 7'h0A)
		else $error("thermal level decode wrong");
	holdoff_map_a: assert property (
		holdoff_bits_o == 16'(config_o.holdoff_bit_count))
		else $error("holdoff count wrong");
	delay_map_a: assert property (chain_delay_cycles_o ==
		14'(config_o.chain_delay_steps * monitor_cfg_pkg::STEP_CYCLES))
		else $error("chain delay cycles wrong");
	port_map_a: assert property (port_enable_o == {4{!config_o.multidrop}})
		else $error("port enables disagree with topology");
	fault_pin_a: assert property (!$past(rst_i) |-> fault_pin_o ==
		!($past(fault_detected_i) && $past(config_o.fault_pin_enable)))
		else $error("fault pin level wrong");
	link_fault_a: assert property (
		link_fault_o |-> $past(config_o.link_fault_detect_enable))
		else $error("link fault while detection off");
	tone_gate_a: assert property (alarm_tone_o |->
		$past(config_o.sleep_alarm_tone_enable &&
			power_state_o == monitor_cfg_pkg::PWR_SLEEP))
		else $error("alarm tone outside enabled sleep");
	pulse_gate_a: assert property (sleep_pulse_o |->
		$past(config_o.sleep_pulse_enable &&
			power_state_o == monitor_cfg_pkg::PWR_SLEEP))
		else $error("heartbeat outside enabled sleep");
	adj_block_a: assert property (config_o.block_adjacent_balancing |->
		(balance_o & (balance_o >> 1)) == 16'h0000)
		else $error("adjacent balancing switches both on");
	off_sticky_a: assert property (
		power_state_o == monitor_cfg_pkg::PWR_SHUTDOWN |=>
		power_state_o == monitor_cfg_pkg::PWR_SHUTDOWN)
		else $error("shutdown left without reset");
	shutdown_c: cover property (power_state_o == monitor_cfg_pkg::PWR_SHUTDOWN);
	flag_c: cover property ($rose(link_timeout_flag_o));
	block_c: cover property (config_o.block_adjacent_balancing &&
		balance_o != 16'h0000);
endmodule : monitor_config_regs_checker

// File: tb/monitor_config_regs_tb.sv
`timescale 1ns/10ps
module monitor_config_regs_tb;
	typedef struct packed {
		logic [7:0] d;
		logic [7:0] m;
	} exp_t;
	// identity values are arbitrary
	localparam logic [63:0] DIE = 64'h1F2E3D4C5B6A7988;
	logic clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic [13:0] wb_adr_i = 14'h0000;
	logic [3:0]  wb_sel_i = 4'h1;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic wake_to_active_i = 1'b0, go_sleep_i = 1'b0, fault_detected_i = 1'b0;
	logic link_fault_state_i = 1'b0, alarm_tone_req_i = 1'b0;
	logic sleep_pulse_req_i = 1'b0;
	logic link_flag_clear_i = 1'b0, p_en = 1'b0, p_slow = 1'b0, frame_valid_i;
	logic [15:0] balance_req_i = 16'h0000, balance_o, holdoff_bits_o;
	logic wb_ack_o, link_timeout_flag_o, link_fault_o;
	logic fault_pin_o, alarm_tone_o, sleep_pulse_o;
	monitor_cfg_pkg::config_t      config_o;
	monitor_cfg_pkg::port_enable_t port_enable_o;
	monitor_cfg_pkg::power_t       power_state_o;
	logic [4:0]  cells_active_o;
	logic [6:0]  thermal_warning_c_o;
	logic [13:0] chain_delay_cycles_o;
	logic [31:0] seed = 32'h549BBDC2;
	logic [7:0]  d, e8;
	logic [11:0] ri [9] = '{12'h002, 12'h003, 12'h005, 12'h006, 12'h018, 12'h019,
		12'h01A, 12'h029, 12'h02A};
	logic [7:0]  rv [9] = '{8'h54, 8'h00, 8'h00, 8'h00, 8'h18, 8'h00,
		8'h00, 8'h00, 8'h00};
	logic [7:0]  rm [9] = '{8'h7F, 8'h0F, 8'hFF, 8'hFF, 8'h1F, 8'h7F,
		8'hFF, 8'h3F, 8'h1F};
	exp_t q[$];
	exp_t e;
	int fails = 0, n_checks = 0, cycles = 0, i;

	always #2.5 clk_i = ~clk_i;
	monitor_config_regs #(.TICK_CYCLES(4), .PART_ID(8'hC3), .SILICON_REV(8'h7E),
		.DEVICE_REV(8'h96), .DIE_BYTES(DIE)) i_dut (.clk_i, .rst_i, .wb_cyc_i,
		.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.frame_valid_i, .wake_to_active_i, .go_sleep_i, .fault_detected_i,
		.link_fault_state_i, .alarm_tone_req_i, .sleep_pulse_req_i, .balance_req_i,
		.link_flag_clear_i, .config_o, .port_enable_o, .power_state_o,
		.link_timeout_flag_o, .link_fault_o, .fault_pin_o, .alarm_tone_o,
		.sleep_pulse_o, .balance_o, .cells_active_o, .thermal_warning_c_o,
		.holdoff_bits_o, .chain_delay_cycles_o);
	link_host_model i_host (.clk_i, .rst_i, .en_i(p_en), .slow_i(p_slow),
		.two_stop_i(config_o.two_stop_bits), .frame_valid_o(frame_valid_i));

	task automatic chk(input logic [31:0] a, input logic [31:0] x);
		n_checks++;
		if (a !== x) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, a, x);
		end
	endtask : chk

	task automatic close_out();
		if (fails == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out

	task automatic do_reset();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask : do_reset

	// read note goes in the queue; monitor compares when ack shows
	task automatic bus(input logic w, input logic [11:0] idx,
		input logic [7:0] x, input logic [7:0] m);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= {idx, 2'b00};
		wb_dat_i <= {24'h000000, x};
		if (!w)
			q.push_back('{x, m});
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : bus

	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && q.size() > 0) begin
			e = q.pop_front();
			chk(wb_dat_o & {24'hFFFFFF, e.m}, {24'h000000, e.d & e.m});
		end
	end

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			close_out();
		end
	end

	initial begin
		do_reset();
		for (i = 0; i < 9; i++) bus(1'b0, ri[i], rv[i], 8'hFF);
		for (i = 0; i < 9; i++) begin
			d = 8'($random(seed));
			bus(1'b1, ri[i], d, 8'h00);
			bus(1'b0, ri[i], d, rm[i]);
		end
		do_reset();
		for (i = 0; i < 11; i++) begin
			e8 = (i == 0) ? 8'hC3 : (i == 1) ? 8'h7E :
				(i < 10) ? DIE[8*(i-2)+:8] : 8'h96;
			bus(1'b1, (i < 10) ? 12'h500 + 12'(i) : 12'hE00, ~e8, 8'h00);
			bus(1'b0, (i < 10) ? 12'h500 + 12'(i) : 12'hE00, e8, 8'hFF);
		end
		bus(1'b0, 12'h7FF, 8'h00, 8'hFF);
		for (i = 0; i < 11; i++) begin
			bus(1'b1, 12'h003, 8'(i), 8'h00);
			#1 chk(32'(cells_active_o), 32'(i + 6));
		end
		for (i = 0; i < 4; i++) begin
			bus(1'b1, 12'h018, 8'(i << 3), 8'h00);
			#1 chk(32'(thermal_warning_c_o), 32'(85 + 10 * i));
		end
		d = 8'($random(seed));
		bus(1'b1, 12'h01A, d, 8'h00);
		bus(1'b1, 12'h029, d, 8'h00);
		bus(1'b1, 12'h02A, d, 8'h00);
		#1 chk(32'(holdoff_bits_o), 32'(d));
		chk(32'(chain_delay_cycles_o), 32'(d[5:0]) * 50);
		chk(32'(config_o.busbar_pin_position), 32'(d[4:0]));
		bus(1'b1, 12'h005, d, 8'h00);
		bus(1'b1, 12'h006, ~d, 8'h00);
		#1 chk(32'(config_o.busbar_cells), 32'({d, ~d}));
		bus(1'b1, 12'h074 - 12'h072, 8'h74, 8'h00);
		#1 chk(32'(port_enable_o), 32'h0);
		bus(1'b1, 12'h002, 8'h54, 8'h00);
		fault_detected_i <= 1'b1;
		link_fault_state_i <= 1'b1;
		balance_req_i <= 16'h0003;
		repeat (2) @(posedge clk_i);
		#1 chk(32'(port_enable_o), 32'hF);
		chk(32'(fault_pin_o), 32'h0);
		chk(32'(link_fault_o), 32'h1);
		chk(32'(balance_o), 32'h0001);
		bus(1'b1, 12'h002, 8'h00, 8'h00);
		balance_req_i <= 16'($random(seed));
		repeat (2) @(posedge clk_i);
		#1 chk(32'(fault_pin_o), 32'h1);
		chk(32'(link_fault_o), 32'h0);
		chk(32'(balance_o), 32'(balance_req_i));
		bus(1'b1, 12'h002, 8'h5C, 8'h00);
		fault_detected_i <= 1'b0;
		#1 chk(32'(config_o.two_stop_bits), 32'h1);
		bus(1'b1, 12'h019, 8'h20, 8'h00);
		p_en <= 1'b1;
		repeat (200) @(posedge clk_i);
		#1 chk(32'(link_timeout_flag_o), 32'h0);
		@(posedge clk_i);
		p_slow <= 1'b1;
		for (i = 0; i < 300 && link_timeout_flag_o !== 1'b1; i++) @(posedge clk_i);
		#1 chk(32'(link_timeout_flag_o), 32'h1);
		bus(1'b1, 12'h019, 8'h00, 8'h00);
		p_en <= 1'b0;
		link_flag_clear_i <= 1'b1;
		@(posedge clk_i);
		link_flag_clear_i <= 1'b0;
		bus(1'b0, 12'hF00, 8'h00, 8'h07);
		bus(1'b1, 12'h019, 8'h01, 8'h00);
		for (i = 0; i < 60 && power_state_o !== 2'b01; i++) @(posedge clk_i);
		bus(1'b0, 12'hF00, 8'h05, 8'h07);
		bus(1'b1, 12'h019, 8'h00, 8'h00);
		alarm_tone_req_i <= 1'b1;
		sleep_pulse_req_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1 chk(32'({alarm_tone_o, sleep_pulse_o}), 32'h0);
		bus(1'b1, 12'h002, 8'h57, 8'h00);
		repeat (2) @(posedge clk_i);
		#1 chk(32'({alarm_tone_o, sleep_pulse_o}), 32'h3);
		bus(1'b1, 12'h018, 8'h19, 8'h00);
		repeat (120) @(posedge clk_i);
		wake_to_active_i <= 1'b1;
		@(posedge clk_i);
		wake_to_active_i <= 1'b0;
		go_sleep_i <= 1'b1;
		@(posedge clk_i);
		go_sleep_i <= 1'b0;
		repeat (150) @(posedge clk_i);
		#1 chk(32'(power_state_o), 32'h1);
		for (i = 0; i < 150 && power_state_o !== 2'b10; i++) @(posedge clk_i);
		#1 chk(32'(power_state_o), 32'h2);
		do_reset();
		bus(1'b1, 12'h019, 8'h09, 8'h00);
		for (i = 0; i < 60 && power_state_o !== 2'b10; i++) @(posedge clk_i);
		bus(1'b0, 12'hF00, 8'h02, 8'h07);
		close_out();
	end
endmodule : monitor_config_regs_tb

bind monitor_config_regs monitor_config_regs_checker i_chk (.clk_i,
	.rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .fault_detected_i, .config_o,
	.port_enable_o,
	.power_state_o, .link_timeout_flag_o, .link_fault_o, .fault_pin_o,
	.alarm_tone_o, .sleep_pulse_o, .balance_o, .cells_active_o,
	.thermal_warning_c_o, .holdoff_bits_o, .chain_delay_cycles_o);
